/* File: rtc_pkg.sv */
package rtc_pkg;

  // Timing: the 25 MHz tick is five 8 ns reference cycles
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned TICK_PERIOD_NS = 40;
  localparam int unsigned PHASE_STEPS    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  PHASE_LAST     = 3'(PHASE_STEPS - 1);
  localparam logic [2:0]  PHASE_ZERO     = 3'h0;
  localparam logic [31:0] TICK_NS        = 32'(TICK_PERIOD_NS);
  localparam logic [31:0] NS_PER_SEC     = 32'h3B9ACA00;

  // Register indices; byte address is four times the index
  localparam int unsigned IDX_W       = 12;
  localparam logic [11:0] IDX_CTRL    = 12'h500;
  localparam logic [11:0] IDX_PHASE   = 12'h502;
  localparam logic [11:0] IDX_NS_HI   = 12'h504;
  localparam logic [11:0] IDX_NS_LO   = 12'h506;
  localparam logic [11:0] IDX_SEC_HI  = 12'h508;
  localparam logic [11:0] IDX_SEC_LO  = 12'h50A;
  localparam logic [11:0] IDX_RATE_HI = 12'h50C;
  localparam logic [11:0] IDX_RATE_LO = 12'h50E;

  // Control register fields
  localparam int unsigned CTL_FREQ_DIS = 15;
  localparam int unsigned CTL_STEP     = 6;
  localparam int unsigned CTL_STEP_DIR = 5;
  localparam int unsigned CTL_READ     = 4;
  localparam int unsigned CTL_LOAD     = 3;
  localparam int unsigned CTL_CONT     = 2;
  localparam int unsigned CTL_ENABLE   = 1;
  localparam int unsigned CTL_RESET    = 0;
  localparam logic [15:0] CTL_RW_MASK  = 16'h8026;

  // Rate register fields
  localparam int unsigned RATE_DIR   = 15;
  localparam int unsigned RATE_HI_W  = 14;
  localparam int unsigned RATE_W     = 30;
  localparam int unsigned FRAC_W     = 32;
  localparam logic [15:0] RATE_MASK  = 16'hFFFF;
  localparam logic [15:0] PHASE_MASK = 16'h0007;

  // Reset values and bus answers
  localparam logic [15:0] REG16_RST   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* File: rtc_reg_if.sv */
`timescale 1ns/10ps
interface rtc_reg_if;
  import rtc_pkg::*;
  logic              wrEn;
  logic [IDX_W-1:0]  wrIdx;
  logic              wrFar;
  logic [15:0]       wrData;
  logic [1:0]        wrStrb;
  logic              wrHit;
  logic [IDX_W-1:0]  rdIdx;
  logic              rdFar;
  logic [15:0]       rdData;
  logic              rdHit;

  modport bus  (output wrEn, wrIdx, wrFar, wrData, wrStrb, rdIdx, rdFar, input wrHit, rdData, rdHit);
  modport regs (input wrEn, wrIdx, wrFar, wrData, wrStrb, rdIdx, rdFar, output wrHit, rdData, rdHit);
endinterface

/* File: rtc_wrap_add.sv */
`timescale 1ns/10ps
module rtc_wrap_add
  import rtc_pkg::*;
#(
  parameter logic [31:0] LIMIT = NS_PER_SEC
)(
  // Operands, both below LIMIT
  input  wire logic [31:0] base,
  input  wire logic [31:0] delta,
  input  wire logic        sub,
  // Result and wrap into the next unit
  output logic [31:0]      result,
  output logic             carry,
  output logic             borrow
);
  logic [32:0] sum;

  always_comb
  begin
    sum    = {1'b0, base} + {1'b0, delta};
    result = sum[31:0];
    carry  = 1'b0;
    borrow = 1'b0;
    if (sub)
    begin
      if (base >= delta)
        result = base - delta;
      else
      begin
        result = base + (LIMIT - delta);
        borrow = 1'b1;
      end
    end
    else if (sum >= {1'b0, LIMIT})
    begin
      result = 32'(sum - {1'b0, LIMIT});
      carry  = 1'b1;
    end
  end
endmodule // rtc_wrap_add

/* File: rtc_axil_slave.sv */
`timescale 1ns/10ps
module rtc_axil_slave
  import rtc_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Register side
  rtc_reg_if.bus                 rb
);
  logic [ADDR_W-1:0] awAddr_r;
  logic              awHeld_r;
  logic [15:0]       wData_r;
  logic [1:0]        wStrb_r;
  logic              wHeld_r;
  logic              wrGo;

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrGo          = awHeld_r && wHeld_r && !s_axi_bvalid;

  assign rb.wrEn   = wrGo;
  assign rb.wrIdx  = awAddr_r[IDX_W+1:2];
  assign rb.wrFar  = |awAddr_r[ADDR_W-1:IDX_W+2];
  assign rb.wrData = wData_r;
  assign rb.wrStrb = wStrb_r;
  assign rb.rdIdx  = s_axi_araddr[IDX_W+1:2];
  assign rb.rdFar  = |s_axi_araddr[ADDR_W-1:IDX_W+2];

  // Address and data are caught independently, in either order
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      awAddr_r <= '0;
      awHeld_r <= 1'b0;
      wData_r  <= REG16_RST;
      wStrb_r  <= 2'h0;
      wHeld_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end
      else if (wrGo)
        awHeld_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_r <= s_axi_wdata[15:0];
        wStrb_r <= s_axi_wstrb[1:0];
        wHeld_r <= 1'b1;
      end
      else if (wrGo)
        wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wrGo)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= rb.wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rb.rdData};
      s_axi_rresp  <= rb.rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // rtc_axil_slave

/* File: rtc_ptp_clock.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Function
// [R1] Step direction zero subtracts the step value from the clock.
// [R2] Step command adds or subtracts the nanosecond hold value; one means add.
// [R3] Read command copies live phase, nanoseconds, seconds into time registers.
// [R4] Load command overwrites live clock from the time registers.
// [R5] Continuous adjust applies the fractional rate every 25 MHz tick when enabled.
// [R6] Rate sign bit in rate high word selects add or subtract.
// [R7] Fractional rate is 30 bits: 14 high, 16 low; sign one adds.
// [R8] Clock advances only while the enable bit is one.
// [R9] Software keeps the clock enabled while trigger output units are used.
// [R10] Reset command returns the clock to zero; command bit reads zero.
// [R11] Three-bit phase names the 8 ns step within 40 ns; resets zero.
// [R12] Phase codes 0..4 mean 0..32 ns; codes 5..7 are invalid.
// [R13] Nanoseconds are 32 bits as two 16-bit words, reset zero.
// [R14] Seconds are 32 bits as two 16-bit words, reset zero.
// [R15] Each tick adds 40 ns plus correction; wraps at one billion into seconds.
module rtc_ptp_clock
  import rtc_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Live time
  output logic [2:0]             rtcPhase,
  output logic [31:0]            rtcNanosec,
  output logic [31:0]            rtcSeconds,
  output logic                   rtcTick,
  // Control levels for the rest of the switch
  output logic                   rtcEnabled,
  output logic                   freqAdjDisable
);

  generate
    if (ADDR_W < IDX_W + 3 || ADDR_W > 32)
    begin : g_bad_addr
      $error("rtc_ptp_clock: ADDR_W must be 15 to 32");
    end
    // Three phase bits must name every reference cycle of one tick
    if (PHASE_STEPS * CLK_PERIOD_NS != TICK_PERIOD_NS || PHASE_STEPS > 8 || FRAC_W < RATE_W)
    begin : g_bad_tick
      $error("rtc_ptp_clock: tick must be up to 8 whole clock periods, fraction must hold the rate");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Bus front end

  rtc_reg_if rb ();

  rtc_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rb            (rb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] ctrl_r;
  logic [2:0]  holdPhase_r;
  logic [31:0] holdNs_r;
  logic [31:0] holdSec_r;
  logic [15:0] rateHi_r;
  logic [15:0] rateLo_r;

  logic [2:0]        phase_r;
  logic [31:0]       ns_r;
  logic [31:0]       sec_r;
  logic [FRAC_W-1:0] frac_r;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  logic wrOk;
  logic wrCtrl;
  logic cmdStep;
  logic cmdRead;
  logic cmdLoad;
  logic cmdReset;

  assign wrOk     = rb.wrEn && rb.wrHit;
  assign wrCtrl   = wrOk && (rb.wrIdx == IDX_CTRL) && rb.wrStrb[0];
  assign cmdStep  = wrCtrl && rb.wrData[CTL_STEP];
  assign cmdRead  = wrCtrl && rb.wrData[CTL_READ];
  assign cmdLoad  = wrCtrl && rb.wrData[CTL_LOAD];
  assign cmdReset = wrCtrl && rb.wrData[CTL_RESET];

  // Commands act in the cycle they are written, so they are never stored and read zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ctrl_r <= REG16_RST;
    else if (wrOk && rb.wrIdx == IDX_CTRL)
      ctrl_r <= merge16(ctrl_r, rb.wrData, rb.wrStrb) & CTL_RW_MASK; // [R10]
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rateHi_r <= REG16_RST;
      rateLo_r <= REG16_RST;
    end
    else if (wrOk)
    begin
      if (rb.wrIdx == IDX_RATE_HI)
        rateHi_r <= merge16(rateHi_r, rb.wrData, rb.wrStrb) & RATE_MASK;
      if (rb.wrIdx == IDX_RATE_LO)
        rateLo_r <= merge16(rateLo_r, rb.wrData, rb.wrStrb);
    end
  end

  // Time registers: written by software, or snapshot of the live clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      holdPhase_r <= PHASE_ZERO; // [R11]
      holdNs_r    <= '0; // [R13]
      holdSec_r   <= '0; // [R14]
    end
    else if (cmdRead)
    begin
      holdPhase_r <= phase_r; // [R3]
      holdNs_r    <= ns_r; // [R3]
      holdSec_r   <= sec_r; // [R3]
    end
    else if (wrOk)
    begin
      case (rb.wrIdx)
        IDX_PHASE:  holdPhase_r <= rb.wrStrb[0] ? rb.wrData[2:0] : holdPhase_r;
        IDX_NS_HI:  holdNs_r[31:16] <= merge16(holdNs_r[31:16], rb.wrData, rb.wrStrb);
        IDX_NS_LO:  holdNs_r[15:0] <= merge16(holdNs_r[15:0], rb.wrData, rb.wrStrb);
        IDX_SEC_HI: holdSec_r[31:16] <= merge16(holdSec_r[31:16], rb.wrData, rb.wrStrb);
        IDX_SEC_LO: holdSec_r[15:0] <= merge16(holdSec_r[15:0], rb.wrData, rb.wrStrb);
        default:    holdPhase_r <= holdPhase_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode

  function automatic logic idxKnown(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_CTRL, IDX_PHASE, IDX_NS_HI, IDX_NS_LO,
      IDX_SEC_HI, IDX_SEC_LO, IDX_RATE_HI, IDX_RATE_LO: idxKnown = 1'b1;
      default: idxKnown = 1'b0;
    endcase
  endfunction

  assign rb.wrHit = !rb.wrFar && idxKnown(rb.wrIdx);
  assign rb.rdHit = !rb.rdFar && idxKnown(rb.rdIdx);

  // Reserved phase bits and unmapped words read as zero
  always_comb
  begin
    case (rb.rdIdx)
      IDX_CTRL:    rb.rdData = ctrl_r;
      IDX_PHASE:   rb.rdData = {13'h0000, holdPhase_r} & PHASE_MASK;
      IDX_NS_HI:   rb.rdData = holdNs_r[31:16];
      IDX_NS_LO:   rb.rdData = holdNs_r[15:0];
      IDX_SEC_HI:  rb.rdData = holdSec_r[31:16];
      IDX_SEC_LO:  rb.rdData = holdSec_r[15:0];
      IDX_RATE_HI: rb.rdData = rateHi_r;
      IDX_RATE_LO: rb.rdData = rateLo_r;
      default:     rb.rdData = REG16_RST;
    endcase
    if (rb.rdFar)
      rb.rdData = REG16_RST;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tick and fractional correction

  logic              running;
  logic              tickNow;
  logic [RATE_W-1:0] rateVal;
  logic              rateAdd;
  logic [FRAC_W:0]   fracSum;
  logic [31:0]       tickDelta;

  assign running = ctrl_r[CTL_ENABLE]; // [R8]
  assign tickNow = running && (phase_r >= PHASE_LAST); // [R11]
  assign rateVal = {rateHi_r[RATE_HI_W-1:0], rateLo_r}; // [R7]
  assign rateAdd = rateHi_r[RATE_DIR]; // [R6]

  // The fraction carries into whole nanoseconds, so the long-term rate is exact
  always_comb
  begin
    if (rateAdd)
      fracSum = {1'b0, frac_r} + {{(FRAC_W + 1 - RATE_W){1'b0}}, rateVal}; // [R7]
    else
      fracSum = {1'b0, frac_r} - {{(FRAC_W + 1 - RATE_W){1'b0}}, rateVal}; // [R7]
    tickDelta = TICK_NS; // [R15]
    if (ctrl_r[CTL_CONT] && fracSum[FRAC_W])
      tickDelta = rateAdd ? TICK_NS + 32'h00000001 : TICK_NS - 32'h00000001; // [R5]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Nanosecond arithmetic

  logic [31:0] nsTicked;
  logic        tickCarry;
  logic [31:0] nsStepped;
  logic        stepCarry;
  logic        stepBorrow;

  rtc_wrap_add #(.LIMIT(NS_PER_SEC)) u_tick_add (
    .base   (ns_r),
    .delta  (tickNow ? tickDelta : 32'h00000000),
    .sub    (1'b0),
    .result (nsTicked),
    .carry  (tickCarry), // [R15]
    .borrow ()
  );

  // Direction comes from the same write as the step bit, so one write aims and fires
  logic stepAdd;
  assign stepAdd = rb.wrData[CTL_STEP_DIR]; // [R2]

  // Step is applied on top of the tick so a coincident tick is not lost
  rtc_wrap_add #(.LIMIT(NS_PER_SEC)) u_step_add (
    .base   (nsTicked),
    .delta  (cmdStep ? holdNs_r : 32'h00000000), // [R2]
    .sub    (!stepAdd), // [R1]
    .result (nsStepped),
    .carry  (stepCarry),
    .borrow (stepBorrow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Live clock

  // Invalid phase codes load as zero rather than running past the tick
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      phase_r <= PHASE_ZERO; // [R11]
    else if (cmdReset)
      phase_r <= PHASE_ZERO; // [R10]
    else if (cmdLoad)
      phase_r <= (holdPhase_r > PHASE_LAST) ? PHASE_ZERO : holdPhase_r; // [R12]
    else if (running)
      phase_r <= tickNow ? PHASE_ZERO : phase_r + 3'h1; // [R8]
  end

  // Software reset outranks load, which outranks tick and step
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ns_r  <= '0; // [R13]
      sec_r <= '0; // [R14]
    end
    else if (cmdReset)
    begin
      ns_r  <= '0; // [R10]
      sec_r <= '0; // [R10]
    end
    else if (cmdLoad)
    begin
      ns_r  <= holdNs_r; // [R4]
      sec_r <= holdSec_r; // [R4]
    end
    else
    begin
      ns_r  <= nsStepped; // [R15]
      sec_r <= sec_r + {31'h00000000, tickCarry} + {31'h00000000, stepCarry}
               - {31'h00000000, stepBorrow}; // [R15]
    end
  end

  // Fraction clears on a reset or load command and otherwise moves only on an enabled tick with continuous adjust on
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      frac_r <= '0;
    else if (cmdReset || cmdLoad)
      frac_r <= '0; // [R10]
    else if (tickNow && ctrl_r[CTL_CONT])
      frac_r <= fracSum[FRAC_W-1:0]; // [R5]
  end

  // Pulse trails the tick by one cycle so it lines up with the new count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rtcTick <= 1'b0;
    else
      rtcTick <= tickNow;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rtcPhase       = phase_r;
  assign rtcNanosec     = ns_r;
  assign rtcSeconds     = sec_r;
  assign rtcEnabled     = ctrl_r[CTL_ENABLE];
  assign freqAdjDisable = ctrl_r[CTL_FREQ_DIS];

endmodule // rtc_ptp_clock

/* File: rtc_ptp_clock_asserts.sv */
`timescale 1ns/10ps
module rtc_ptp_clock_asserts
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Live time
  input wire logic [2:0]  rtcPhase,
  input wire logic [31:0] rtcNanosec,
  input wire logic [31:0] rtcSeconds,
  input wire logic        rtcTick,
  input wire logic        rtcEnabled
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Commands land on the edge that raises bvalid, so that edge may move the time
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_tick_due;
    rtcEnabled && rtcPhase == PHASE_LAST;
  endsequence
  a_phase_range: assert property (rtcPhase <= PHASE_LAST)
    else $error("phase code out of range");
  a_phase_steps: assert property (rtcEnabled && rtcPhase < PHASE_LAST |=>
    rtcPhase == $past(rtcPhase) + 3'h1 || $rose(s_axi_bvalid)) else $error("phase did not step");
  a_phase_wraps: assert property (s_tick_due |=> rtcPhase == PHASE_ZERO || $rose(s_axi_bvalid))
    else $error("phase did not wrap");
  a_clock_stops: assert property (!rtcEnabled |=>
    $stable(rtcNanosec) && $stable(rtcPhase) || $rose(s_axi_bvalid)) else $error("clock moved while off");
  a_tick_adds: assert property (s_tick_due ##0 rtcNanosec < NS_PER_SEC - 32'h29 |=>
    (rtcNanosec - $past(rtcNanosec)) inside {32'h27, 32'h28, 32'h29} || $rose(s_axi_bvalid))
    else $error("tick step wrong");
  a_ns_wraps: assert property (s_tick_due ##0 rtcNanosec >= NS_PER_SEC - 32'h27 |=>
    rtcSeconds == $past(rtcSeconds) + 32'h1 && rtcNanosec < 32'h2A || $rose(s_axi_bvalid))
    else $error("seconds did not carry");
  a_tick_source: assert property (rtcTick |-> $past(rtcEnabled) && $past(rtcPhase) == PHASE_LAST)
    else $error("tick pulse without tick");
  a_wr_latency: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
endmodule // rtc_ptp_clock_asserts

bind rtc_ptp_clock rtc_ptp_clock_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .rtcPhase(rtcPhase),
  .rtcNanosec(rtcNanosec), .rtcSeconds(rtcSeconds), .rtcTick(rtcTick), .rtcEnabled(rtcEnabled));

/* File: rtc_ptp_clock_tb_top.sv */
`timescale 1ns/10ps
module rtc_ptp_clock_tb_top
  import rtc_pkg::*;
;
  logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, tick, enabled, fadis;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ns, sec, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  phase;
  int          errors, samples_checked, cycles, ticks;

  rtc_ptp_clock DUT (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rtcPhase(phase),
    .rtcNanosec(ns), .rtcSeconds(sec), .rtcTick(tick), .rtcEnabled(enabled), .freqAdjDisable(fadis));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Ticks are counted so the continuous case needs no cycle-exact model
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (cycles == 6000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [63:0] step_fn(input logic [63:0] t, input logic [31:0] d, input logic add);
    logic [31:0] s, n;
    s = t[63:32];
    n = t[31:0];
    if (add) n = n + d;
    else if (n >= d) n = n - d;
    else {s, n} = {s - 32'h1, n + NS_PER_SEC - d};
    if (n >= NS_PER_SEC) {s, n} = {s + 32'h1, n - NS_PER_SEC};
    return {s, n};
  endfunction
  // Fraction starts at zero after a load, so a subtract borrows on the first tick
  function automatic logic [31:0] cont_fn(input int t, input logic [29:0] r, input int m);
    logic [63:0] p;
    logic [31:0] b;
    p = 64'(t) * 64'(r);
    b = 32'h000003E8 + TICK_NS * 32'(t);
    if (m == 1) return b + p[63:32];
    if (m == 2) return b - 32'((p + 64'hFFFFFFFF) >> 32);
    return b;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_live(input logic [2:0] p, input logic [31:0] n, input logic [31:0] s);
    chk({29'h0, phase}, {29'h0, p}, "live phase");
    chk(ns, n, "live ns");
    chk(sec, s, "live sec");
  endtask
  task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge ref_clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write resp");
  endtask
  task automatic rd(input logic [11:0] idx, input logic [15:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge ref_clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {16'h0000, e}, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read resp");
  endtask
  task automatic set_time(input logic [2:0] p, input logic [31:0] n, input logic [31:0] s);
    wr(IDX_PHASE, {13'h1FFF, p});
    wr(IDX_NS_HI, n[31:16]);
    wr(IDX_NS_LO, n[15:0]);
    wr(IDX_SEC_HI, s[31:16]);
    wr(IDX_SEC_LO, s[15:0]);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [11:0] idxs [8];
    logic [63:0] t;
    logic [31:0] d;
    logic [29:0] r;
    logic [2:0]  p;
    idxs = '{IDX_CTRL, IDX_PHASE, IDX_NS_HI, IDX_NS_LO, IDX_SEC_HI, IDX_SEC_LO, IDX_RATE_HI, IDX_RATE_LO};
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    {errors, samples_checked, cycles, ticks} = '0;
    seed = 32'h5B8394DC;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (idxs[i]) rd(idxs[i], REG16_RST);
    rd(12'h501, 16'h0000, RESP_SLVERR);
    wr(12'h501, 16'hFFFF, RESP_SLVERR);
    // Reserved bits must read back as zero
    wr(IDX_CTRL, 16'hFFA4);
    rd(IDX_CTRL, 16'h8024);
    chk({31'h0, fadis}, 32'h1, "freq adj off");
    wr(IDX_CTRL, 16'h0000);
    repeat (4)
    begin
      seed = lfsr(seed);
      p = 3'(seed % 5);
      t[31:0] = lfsr(seed) % NS_PER_SEC;
      seed = lfsr(lfsr(seed));
      t[63:32] = seed;
      set_time(p, t[31:0], t[63:32]);
      rd(IDX_PHASE, {13'h0, p});
      rd(IDX_NS_LO, t[15:0]);
      rd(IDX_SEC_HI, t[63:48]);
      wr(IDX_CTRL, 16'h0008);
      repeat (10) @(posedge ref_clk);
      chk_live(p, t[31:0], t[63:32]);
      rd(IDX_CTRL, 16'h0000);
    end
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      d = (k == 2) ? t[31:0] + 32'h1 : seed % NS_PER_SEC;
      wr(IDX_NS_HI, d[31:16]);
      wr(IDX_NS_LO, d[15:0]);
      wr(IDX_CTRL, (k == 0) ? 16'h0060 : 16'h0040);
      t = step_fn(t, d, k == 0);
      chk_live(p, t[31:0], t[63:32]);
    end
    set_time(3'h2, seed, ~seed);
    wr(IDX_CTRL, 16'h0010);
    rd(IDX_PHASE, {13'h0, p});
    rd(IDX_NS_HI, t[31:16]);
    rd(IDX_NS_LO, t[15:0]);
    rd(IDX_SEC_HI, t[63:48]);
    rd(IDX_SEC_LO, t[47:32]);
    set_time(3'h0, NS_PER_SEC - 32'h64, 32'h5);
    wr(IDX_CTRL, 16'h0008);
    wr(IDX_CTRL, 16'h0002);
    chk({31'h0, enabled}, 32'h1, "clock enabled");
    repeat (60) @(posedge ref_clk);
    chk(sec, 32'h6, "seconds carry");
    for (int m = 0; m < 3; m++)
    begin
      seed = lfsr(seed);
      r = seed[29:0];
      wr(IDX_RATE_HI, {m != 2, seed[30], r[29:16]});
      wr(IDX_RATE_LO, r[15:0]);
      rd(IDX_RATE_HI, {m != 2, seed[30], r[29:16]});
      wr(IDX_CTRL, 16'h0000);
      set_time(3'h0, 32'h000003E8, 32'h0);
      wr(IDX_CTRL, 16'h0008);
      repeat (10) @(posedge ref_clk);
      ticks = 0;
      wr(IDX_CTRL, (m == 0) ? 16'h0002 : 16'h0006);
      repeat (20 + seed[31:27]) @(posedge ref_clk);
      wr(IDX_CTRL, 16'h0000);
      repeat (20) @(posedge ref_clk);
      chk(ns, cont_fn(ticks, r, m), "continuous");
      chk(sec, 32'h0, "continuous sec");
      chk(ticks, (32'h18 + 32'(seed[31:27])) / 32'h5, "tick count");
    end
    wr(IDX_CTRL, 16'h0001);
    chk_live(3'h0, 32'h0, 32'h0);
    rd(IDX_CTRL, 16'h0000);
    tally_and_finish();
  end
endmodule // rtc_ptp_clock_tb_top
